// ### inc/spi_port_defs.svh
// Constants shared by both ends of the host serial register port.
// Assumes inclusion by bare name from files found on the include path.
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH

// Datagram geometry, counted in bits
`define SPI_DGRAM_BITS 40
`define SPI_DGRAM_LEN 6'h28
`define SPI_DATA_BITS 32
`define SPI_ADDR_BITS 7
`define SPI_STATUS_BITS 8

// Field positions inside the 40-bit datagram
`define SPI_W_BIT 39
`define SPI_ADDR_MSB 38
`define SPI_ADDR_LSB 32
`define SPI_STAT_MSB 39
`define SPI_STAT_LSB 32
`define SPI_DATA_MSB 31
`define SPI_DATA_LSB 0

// Write flag added to the address to form the address byte
`define SPI_WRITE_FLAG 8'h80

// Reset values
`define SPI_RET_RESET 32'h0000_0000
`define SPI_CNT_RESET 6'h00

// Host timing: serial clock half period and select high gap, in core
// cycles; eight gives a serial clock of one sixteenth of the core clock
`define SPI_HOST_HALF 8'h08
`define SPI_HOST_GAP 8'h08

`endif

// ### inc/spi_port_pkg.sv
// Types shared by both ends of the host serial register port.
// Assumes spi_port_defs.svh for the widths it names.
`include "spi_port_defs.svh"

package spi_port_pkg;

   // Access kind carried in the top datagram bit
   typedef enum logic {
      ACC_READ  = 1'b0,
      ACC_WRITE = 1'b1
   } access_t;

   // Outgoing command layout, most significant bit sent first
   typedef struct packed {
      access_t                    acc;
      logic [`SPI_ADDR_BITS-1:0] addr;
      logic [`SPI_DATA_BITS-1:0] data;
   } datagram_t;

   // Host sequencer states, one-hot
   typedef enum logic [4:0] {
      H_IDLE = 5'h01,
      H_LEAD = 5'h02,
      H_HIGH = 5'h04,
      H_LOW  = 5'h08,
      H_GAP  = 5'h10
   } host_state_t;

endpackage

// ### inc/spi_link_if.sv
// Four-wire serial link between the host end and the device end.
// Assumes the bench joins both modports; no clocking block is used.
`timescale 1ns/1ns
`default_nettype none

interface spi_link_if;
   logic host_select_n;     // Frame select, active low, from host
   logic host_serial_clock; // Serial clock from host, idle low
   logic host_serial_in;    // Data host to device
   logic host_serial_out;   // Data device to host

   // Documented device: receives clock, select and data in
   modport device (
      input  host_select_n,
      input  host_serial_clock,
      input  host_serial_in,
      output host_serial_out
   );

   // Bus master: drives clock, select and data in
   modport host (
      output host_select_n,
      output host_serial_clock,
      output host_serial_in,
      input  host_serial_out
   );
endinterface

`default_nettype wire

// ### verilog/spi_device_end.sv
// Device end of the host serial register port: 40-bit full-duplex
// datagrams carrying a write flag, a 7-bit address and 32 data bits in,
// a status byte and 32 bits of pipelined read or echo data out.
// Assumes the host keeps the serial clock idle low, at most a quarter of
// core_clk_i, and holds select high for several core cycles between
// frames; the register file sits on the user-side ports.
`include "spi_port_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module spi_device_end #(
   parameter logic [127:0] WR_MASK = {128{1'b1}}, // Writable addresses
   parameter logic [127:0] RD_MASK = {128{1'b1}}  // Readable addresses
) (
   input  wire logic core_clk_i,             // System clock
   input  wire logic rstn_i,                 // Async reset, active low
   spi_link_if.device link,                  // Serial link to host
   input  wire logic [7:0] status_i,         // Status byte to report
   input  wire logic [31:0] reg_rdata_i,     // Register read data
   output logic [6:0] reg_addr_o,            // Register address
   output logic [31:0] reg_wdata_o,          // Register write data
   output logic reg_wr_o,                    // Write strobe, one cycle
   output logic reg_rd_o,                    // Read strobe, one cycle
   output logic frame_err_o                  // Short frame, one cycle
);

   // Link domain: receive shift register on the serial clock
   logic [`SPI_DGRAM_BITS-1:0] rx_word_ff; // Last forty bits seen

   // Core domain: synchronisers, first stages read only by second
   logic sel_s1_ff, sel_s2_ff, sel_d_ff;   // Select sync and delay
   logic sck_s1_ff, sck_s2_ff, sck_d_ff;   // Clock sync and delay
   logic sdi_s1_ff, sdi_s2_ff;             // Data in sync

   // Core domain: frame bookkeeping
   logic [5:0] bit_cnt_ff;                 // Rising edges, saturating
   logic rx_bit_ff;                        // Bit sampled at last rise
   logic [`SPI_DGRAM_BITS-1:0] tx_ff;      // Outgoing shift register
   logic sdo_ff;                           // Pin driver flop
   logic [31:0] ret_ff;                    // Data for next frame
   spi_port_pkg::datagram_t cmd_ff;        // Latched command
   logic cmd_vld_ff;                       // Command ready to execute
   logic rd_pend_ff;                       // Read command executed, strobed or not
   logic rd_ok_ff;                         // Issued read is allowed
   logic wr_ff, rd_ff, err_ff;             // Strobe flops
   logic [6:0] addr_ff;                    // Address output flop
   logic [31:0] wdata_ff;                  // Write data output flop

   // Looks up one address in an access mask
   function automatic logic addr_allowed(input logic [127:0] mask,
                                         input logic [6:0] addr);
      addr_allowed = mask[addr];
   endfunction

   // Edge decode on synchronised inputs; the serial clock only counts
   // while select is low so that stray edges between frames do nothing
   wire sel_fall = sel_d_ff & ~sel_s2_ff;
   wire sel_rise = ~sel_d_ff & sel_s2_ff;
   wire in_frame = ~sel_s2_ff;
   wire sck_rise = in_frame & sck_s2_ff & ~sck_d_ff;
   wire sck_fall = in_frame & ~sck_s2_ff & sck_d_ff;
   wire frame_full = (bit_cnt_ff == `SPI_DGRAM_LEN);
   wire is_write = (cmd_ff.acc == spi_port_pkg::ACC_WRITE);
   wire wr_ok = addr_allowed(WR_MASK, cmd_ff.addr);
   wire rd_ok = addr_allowed(RD_MASK, cmd_ff.addr);

   // Receive shift on the rising serial edge, MSB first; the register
   // simply keeps the last forty bits, so overlong frames end up
   // holding the tail of the stream
   always_ff @(posedge link.host_serial_clock or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_word_ff <= '0;
      end else begin
         rx_word_ff <= {rx_word_ff[`SPI_DGRAM_BITS-2:0],
                        link.host_serial_in};
      end
   end

   // Two-stage synchronisers into the core clock
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sel_s1_ff <= 1'b1;
         sel_s2_ff <= 1'b1;
         sel_d_ff <= 1'b1;
         sck_s1_ff <= 1'b0;
         sck_s2_ff <= 1'b0;
         sck_d_ff <= 1'b0;
         sdi_s1_ff <= 1'b0;
         sdi_s2_ff <= 1'b0;
      end else begin
         sel_s1_ff <= link.host_select_n;
         sel_s2_ff <= sel_s1_ff;
         sel_d_ff <= sel_s2_ff;
         sck_s1_ff <= link.host_serial_clock;
         sck_s2_ff <= sck_s1_ff;
         sck_d_ff <= sck_s2_ff;
         sdi_s1_ff <= link.host_serial_in;
         sdi_s2_ff <= sdi_s1_ff;
      end
   end

   // Count rising serial edges; saturates at forty because only the
   // question "were there at least forty" matters for validity
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bit_cnt_ff <= `SPI_CNT_RESET;
      end else if (sel_fall) begin
         bit_cnt_ff <= `SPI_CNT_RESET;
      end else if (sck_rise && !frame_full) begin
         bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
   end

   // Transmit path: the status byte and the held word are loaded when
   // select falls, then one bit leaves per falling edge while the bit
   // just received enters at the bottom; extra clocks therefore push
   // incoming bits out forty clocks later, which daisy chains
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_ff <= '0;
         sdo_ff <= 1'b0;
         rx_bit_ff <= 1'b0;
      end else begin
         if (sck_rise) begin
            rx_bit_ff <= sdi_s2_ff;
         end
         if (sel_fall) begin
            tx_ff <= {status_i, ret_ff};
            sdo_ff <= status_i[7];
         end else if (sck_fall) begin
            tx_ff <= {tx_ff[`SPI_DGRAM_BITS-2:0], rx_bit_ff};
            sdo_ff <= tx_ff[`SPI_DGRAM_BITS-2];
         end
      end
   end

   // Latch the command at select rise. The receive word is stable here:
   // the serial clock has been still for at least the sync delay, so
   // the multi-bit capture across domains cannot tear
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cmd_ff <= '0;
         cmd_vld_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         cmd_vld_ff <= sel_rise && frame_full;
         err_ff <= sel_rise && !frame_full;
         if (sel_rise) begin
            cmd_ff <= spi_port_pkg::datagram_t'(rx_word_ff);
         end
      end
   end

   // Execute: writes update the echo word at once; reads strobe the
   // register file and capture its answer the next cycle, well before
   // the next frame can start shifting it out
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         rd_ok_ff <= 1'b0;
         addr_ff <= '0;
         wdata_ff <= '0;
         ret_ff <= `SPI_RET_RESET;
      end else begin
         wr_ff <= cmd_vld_ff && is_write && wr_ok;
         rd_ff <= cmd_vld_ff && !is_write && rd_ok;
         rd_pend_ff <= cmd_vld_ff && !is_write;
         rd_ok_ff <= rd_ok;
         if (cmd_vld_ff) begin
            addr_ff <= cmd_ff.addr;
            if (is_write) begin
               wdata_ff <= cmd_ff.data;
               ret_ff <= cmd_ff.data;
            end
         end
         if (rd_pend_ff) begin
            // Unreadable addresses answer zero
            ret_ff <= rd_ok_ff ? reg_rdata_i : '0;
         end
      end
   end

   // Outputs straight from flops
   assign link.host_serial_out = sdo_ff;
   assign reg_addr_o = addr_ff;
   assign reg_wdata_o = wdata_ff;
   assign reg_wr_o = wr_ff;
   assign reg_rd_o = rd_ff;
   assign frame_err_o = err_ff;

endmodule

`default_nettype wire

// ### verilog/spi_host_end.sv
// Host end of the serial register port: turns one command into a
// 40-bit datagram and returns the status byte and data word received.
// Assumes the device end is joined through spi_link_if.
`include "spi_port_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module spi_host_end #(
   parameter logic [7:0] HALF_CYCLES = `SPI_HOST_HALF, // Clock half period
   parameter logic [7:0] GAP_CYCLES = `SPI_HOST_GAP    // Select high time
) (
   input  wire logic core_clk_i,           // Host clock
   input  wire logic rstn_i,               // Async reset, active low
   spi_link_if.host link,                  // Serial link to device
   input  wire logic cmd_valid_i,          // Command offered
   input  wire logic cmd_write_i,          // One for write
   input  wire logic [6:0] cmd_addr_i,     // Register address
   input  wire logic [31:0] cmd_wdata_i,   // Write data or dummy
   output logic cmd_ready_o,               // Ready to take a command
   output logic resp_valid_o,              // Answer pulse, one cycle
   output logic [7:0] resp_status_o,       // Received status byte
   output logic [31:0] resp_data_o         // Received data word
);

   spi_port_pkg::host_state_t state_ff;    // Sequencer state
   logic [7:0] tim_ff;                     // Cycle timer
   logic [5:0] bits_ff;                    // Rising edges sent
   logic [39:0] tx_ff;                     // Outgoing bits
   logic [39:0] rx_ff;                     // Incoming bits
   logic sel_n_ff, sck_ff, mosi_ff;        // Pin flops
   logic miso_s1_ff, miso_s2_ff;           // Data in sync
   logic ready_ff, resp_ff;                // Handshake flops

   // Address byte is the write flag added to the address
   wire [7:0] addr_byte = (cmd_write_i ? `SPI_WRITE_FLAG : 8'h00)
                          + {1'b0, cmd_addr_i};
   wire tim_done = (tim_ff == HALF_CYCLES - 8'h01);
   wire gap_done = (tim_ff == GAP_CYCLES - 8'h01);
   wire take = ready_ff && cmd_valid_i;
   wire last_bit = (bits_ff == `SPI_DGRAM_LEN);

   // Device output crosses two flops before use
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         miso_s1_ff <= 1'b0;
         miso_s2_ff <= 1'b0;
      end else begin
         miso_s1_ff <= link.host_serial_out;
         miso_s2_ff <= miso_s1_ff;
      end
   end

   // Sequencer: the serial clock is divided down from the host clock;
   // a half period of eight keeps it well under a quarter of the
   // device clock and leaves room for the device's sync delay
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff <= spi_port_pkg::H_IDLE;
         tim_ff <= 8'h00;
         bits_ff <= `SPI_CNT_RESET;
         tx_ff <= '0;
         rx_ff <= '0;
         sel_n_ff <= 1'b1;
         sck_ff <= 1'b0;
         mosi_ff <= 1'b0;
         ready_ff <= 1'b0;
         resp_ff <= 1'b0;
      end else begin
         resp_ff <= 1'b0;
         tim_ff <= tim_ff + 8'h01;
         case (state_ff)
            spi_port_pkg::H_IDLE: begin
               ready_ff <= 1'b1;
               tim_ff <= 8'h00;
               if (take) begin
                  ready_ff <= 1'b0;
                  tx_ff <= {addr_byte, cmd_wdata_i};
                  mosi_ff <= addr_byte[7];
                  sel_n_ff <= 1'b0;
                  bits_ff <= `SPI_CNT_RESET;
                  state_ff <= spi_port_pkg::H_LEAD;
               end
            end
            spi_port_pkg::H_LEAD, spi_port_pkg::H_LOW: begin
               if (tim_done) begin
                  tim_ff <= 8'h00;
                  if (last_bit) begin
                     sel_n_ff <= 1'b1;
                     resp_ff <= 1'b1;
                     state_ff <= spi_port_pkg::H_GAP;
                  end else begin
                     sck_ff <= 1'b1;
                     rx_ff <= {rx_ff[38:0], miso_s2_ff};
                     bits_ff <= bits_ff + 6'h01;
                     state_ff <= spi_port_pkg::H_HIGH;
                  end
               end
            end
            spi_port_pkg::H_HIGH: begin
               if (tim_done) begin
                  tim_ff <= 8'h00;
                  sck_ff <= 1'b0;
                  tx_ff <= {tx_ff[38:0], 1'b0};
                  mosi_ff <= tx_ff[38];
                  state_ff <= spi_port_pkg::H_LOW;
               end
            end
            spi_port_pkg::H_GAP: begin
               if (gap_done) begin
                  tim_ff <= 8'h00;
                  state_ff <= spi_port_pkg::H_IDLE;
               end
            end
            default: begin
               state_ff <= spi_port_pkg::H_IDLE;
            end
         endcase
      end
   end

   // Outputs straight from flops
   assign link.host_select_n = sel_n_ff;
   assign link.host_serial_clock = sck_ff;
   assign link.host_serial_in = mosi_ff;
   assign cmd_ready_o = ready_ff;
   assign resp_valid_o = resp_ff;
   assign resp_status_o = rx_ff[39:32];
   assign resp_data_o = rx_ff[31:0];

endmodule

`default_nettype wire

// ### tb/host_spi_register_port_asserts.sv
// Wire checks for the serial link between the host end and device end.
// Assumes it is instantiated beside the interface joining both ends.
`timescale 1ns/1ns
`default_nettype none

module host_spi_register_port_asserts #(
   parameter int HALF_CYCLES = 12 // Serial clock half period, host cycles
) (
   input wire logic core_clk_i,        // Host core clock
   input wire logic link_clk_i,        // Device clock
   input wire logic rstn_i,            // Reset, active low
   input wire logic host_select_n,     // Frame select
   input wire logic host_serial_clock, // Serial clock
   input wire logic host_serial_in,    // Data to the device
   input wire logic host_serial_out    // Data from the device
);
   logic sck_q_ff; // Serial clock one host cycle ago
   logic [7:0] run_cnt_ff; // Host cycles since the clock last moved
   logic [7:0] rise_cnt_ff; // Rising serial edges in the current frame
   logic sck_moved; // Clock level differs from last cycle
   logic sck_rise; // Clock has just gone high
   logic [7:0] nxt_run_cnt; // Next cycle count
   logic [7:0] nxt_rise_cnt; // Next rise count, cleared between frames

   assign sck_moved = host_serial_clock != sck_q_ff;
   assign sck_rise = host_serial_clock && !sck_q_ff;
   assign nxt_run_cnt = sck_moved ? 8'h01 : run_cnt_ff + 8'h01;
   assign nxt_rise_cnt = host_select_n ? 8'h00 :
                         (sck_rise ? rise_cnt_ff + 8'h01 : rise_cnt_ff);

   // Helper state; counts are sampled a cycle late, hence equality checks
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sck_q_ff <= 1'b0;
         run_cnt_ff <= 8'h00;
         rise_cnt_ff <= 8'h00;
      end else begin
         sck_q_ff <= host_serial_clock;
         run_cnt_ff <= nxt_run_cnt;
         rise_cnt_ff <= nxt_rise_cnt;
      end
   end

   a_sck_idle_low: assert property (@(posedge core_clk_i)
      disable iff (!rstn_i) host_select_n |-> !host_serial_clock)
      else $error("serial clock high outside a frame");
   a_select_held_low: assert property (@(posedge core_clk_i)
      disable iff (!rstn_i) $rose(host_serial_clock) |-> !host_select_n [*8])
      else $error("select released too soon after a clock rise");
   a_first_rise_delay: assert property (@(posedge core_clk_i)
      disable iff (!rstn_i)
      $fell(host_select_n) |-> ##HALF_CYCLES $rose(host_serial_clock))
      else $error("first clock rise not one half period after select");
   a_fall_spacing: assert property (@(posedge core_clk_i)
      disable iff (!rstn_i)
      (sck_q_ff && !host_serial_clock) |-> run_cnt_ff == 8'(HALF_CYCLES))
      else $error("serial clock high time wrong");
   a_forty_rises: assert property (@(posedge core_clk_i)
      disable iff (!rstn_i) $rose(host_select_n) |-> rise_cnt_ff == 8'h28)
      else $error("frame did not carry forty clock rises");
   a_select_gap: assert property (@(posedge core_clk_i)
      disable iff (!rstn_i) $rose(host_select_n) |-> host_select_n [*8])
      else $error("select high gap too short");
   a_din_on_fall: assert property (@(posedge core_clk_i)
      disable iff (!rstn_i)
      ($changed(host_serial_in) && !host_select_n && $past(host_select_n) == 1'b0)
      |-> $fell(host_serial_clock))
      else $error("host data moved away from a falling clock");
   a_sdo_low_phase: assert property (@(posedge link_clk_i)
      disable iff (!rstn_i)
      ($changed(host_serial_out) && !host_select_n) |-> !host_serial_clock)
      else $error("device data moved while the clock was high");
endmodule

`default_nettype wire

// ### tb/host_spi_register_port_tb.sv
// Testbench: host end and device end face each other over one link; a
// second device end is driven bit by bit to send short and long frames.
// Assumes the design files and headers are on the include path.
`timescale 1ns/1ns
`default_nettype none

module host_spi_register_port_tb;
   localparam logic [127:0] WR_M = ~(128'h1 << 16); // 0x10 read-only
   localparam logic [127:0] RD_M = ~(128'h1 << 17); // 0x11 write-only
   logic core_clk = 1'b0; // Host clock, 8 ns
   logic link_clk = 1'b0; // Device clock, 12 ns, own phase
   logic rstn = 1'b0; // Shared reset
   logic cmd_valid = 1'b0; // Command handshake towards the host end
   logic cmd_write = 1'b0;
   logic [6:0] cmd_addr = 7'h00;
   logic [31:0] cmd_wdata = 32'h0000_0000;
   logic cmd_ready, resp_valid, reg_wr, wr2, err2;
   logic [7:0] resp_status;
   logic [31:0] resp_data, reg_wdata, wdata2;
   logic [6:0] reg_addr, waddr2;
   logic [7:0] status = 8'h00; // Status offered to the device
   logic [7:0] stat2 = 8'hC3; // Status of the second device, fixed
   logic [31:0] regs [0:127]; // Register file behind the device
   logic [31:0] exp_regs [0:127]; // What the registers should hold
   logic [31:0] pend = 32'h0000_0000; // Word due in the next response
   logic [3:0] wr2_cnt = 4'h0; // Write strobes of the second device
   logic [3:0] err2_cnt = 4'h0; // Short frame pulses of the second device
   logic reg_rd, err1; // Read strobe and short frame pulse, first device
   logic [3:0] rd_cnt = 4'h0; // Read strobes of the first device
   logic [3:0] wr_cnt = 4'h0; // Write strobes of the first device
   logic [3:0] err_cnt = 4'h0; // Short frame pulses of the first device
   logic b_sel_n = 1'b1; // Bench-driven link, host side
   logic b_sck = 1'b0;
   logic b_din = 1'b0;
   logic [63:0] rx; // Bits received on the bench-driven link
   int num_errors = 0;
   int checks_done = 0;

   spi_link_if link();
   spi_link_if link2();
   assign link2.host_select_n = b_sel_n;
   assign link2.host_serial_clock = b_sck;
   assign link2.host_serial_in = b_din;

   always #4 core_clk = ~core_clk;
   // Offset start keeps the two clocks out of step
   initial begin
      #3;
      forever #6 link_clk = ~link_clk;
   end

   spi_host_end #(.HALF_CYCLES(8'h0C), .GAP_CYCLES(8'h0C)) u_spi_host_end (
      .core_clk_i(core_clk), .rstn_i(rstn), .link(link.host),
      .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
      .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
      .cmd_ready_o(cmd_ready), .resp_valid_o(resp_valid),
      .resp_status_o(resp_status), .resp_data_o(resp_data));
   spi_device_end #(.WR_MASK(WR_M), .RD_MASK(RD_M)) u_spi_device_end (
      .core_clk_i(link_clk), .rstn_i(rstn), .link(link.device),
      .status_i(status), .reg_rdata_i(regs[reg_addr]),
      .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr),
      .reg_rd_o(reg_rd), .frame_err_o(err1));
   spi_device_end u_spi_device_end_b (
      .core_clk_i(link_clk), .rstn_i(rstn), .link(link2.device),
      .status_i(stat2), .reg_rdata_i(32'h0000_0000),
      .reg_addr_o(waddr2), .reg_wdata_o(wdata2), .reg_wr_o(wr2),
      .reg_rd_o(), .frame_err_o(err2));
   host_spi_register_port_asserts #(.HALF_CYCLES(12))
      u_host_spi_register_port_asserts (
      .core_clk_i(core_clk), .link_clk_i(link_clk), .rstn_i(rstn),
      .host_select_n(link.host_select_n),
      .host_serial_clock(link.host_serial_clock),
      .host_serial_in(link.host_serial_in),
      .host_serial_out(link.host_serial_out));

   // Register file reads combinationally at reg_addr; writes land on the strobe edge
   always @(posedge link_clk) begin
      if (reg_wr === 1'b1) regs[reg_addr] <= reg_wdata;
      // Strobe counts show which accesses really reached the registers
      if (reg_wr === 1'b1) wr_cnt <= wr_cnt + 4'h1;
      if (reg_rd === 1'b1) rd_cnt <= rd_cnt + 4'h1;
      if (err1 === 1'b1) err_cnt <= err_cnt + 4'h1;
   end
   // Watch the strobes of the second device
   always @(posedge link_clk) begin
      if (wr2 === 1'b1) wr2_cnt <= wr2_cnt + 4'h1;
      if (err2 === 1'b1) err2_cnt <= err2_cnt + 4'h1;
   end

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One command through the host end; the expected word is the one left
   // pending by the previous command
   task automatic do_cmd(input logic w, input logic [6:0] a,
                         input logic [31:0] d);
      logic [31:0] exp;
      logic [7:0] st;
      int n;
      exp = pend;
      st = 8'h5A ^ {w, a};
      @(posedge core_clk);
      #1 n = 0;
      while (cmd_ready !== 1'b1 && n < 2000) begin
         @(posedge core_clk);
         #1 n++;
      end
      if (n >= 2000) num_errors++;
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_addr = a;
      cmd_wdata = d;
      status = st;
      @(posedge core_clk);
      #1 cmd_valid = 1'b0;
      n = 0;
      while (resp_valid !== 1'b1 && n < 2000) begin
         @(posedge core_clk);
         #1 n++;
      end
      if (n >= 2000) num_errors++;
      chk({8'h00, resp_status, resp_data}, {8'h00, st, exp});
      if (w) begin
         pend = d;
         if (WR_M[a]) exp_regs[a] = d;
      end else begin
         pend = RD_M[a] ? exp_regs[a] : 32'h0000_0000;
      end
   endtask

   // Bit-banged frame on the second link, twelve host cycles a half period
   task automatic bb_frame(input int nb, input logic [63:0] tx);
      rx = 64'h0;
      @(posedge core_clk);
      #1 b_sel_n = 1'b0;
      for (int i = nb - 1; i >= 0; i--) begin
         b_din = tx[i];
         repeat (12) @(posedge core_clk);
         #1 rx = {rx[62:0], link2.host_serial_out};
         b_sck = 1'b1;
         repeat (12) @(posedge core_clk);
         #1 b_sck = 1'b0;
      end
      repeat (12) @(posedge core_clk);
      #1 b_sel_n = 1'b1;
      b_din = ~b_din; // Released line does not keep its last value
      repeat (16) @(posedge core_clk);
   endtask

   task automatic t_pipeline();
      do_cmd(1'b0, 7'h21, 32'h0000_0000);
      do_cmd(1'b0, 7'h22, 32'h0000_0000);
      do_cmd(1'b1, 7'h22, 32'h00AB_CDEF);
      do_cmd(1'b1, 7'h22, 32'h0012_3456);
      do_cmd(1'b0, 7'h22, 32'hFFFF_FFFF);
      do_cmd(1'b0, 7'h21, 32'h0000_0000);
      do_cmd(1'b0, 7'h21, 32'h0000_0000);
   endtask

   task automatic t_masks();
      do_cmd(1'b1, 7'h10, 32'hFFFF_FFFF);
      do_cmd(1'b0, 7'h10, 32'h0000_0000);
      do_cmd(1'b0, 7'h11, 32'h0000_0000);
      do_cmd(1'b1, 7'h7F, 32'h8000_0001);
      do_cmd(1'b0, 7'h7F, 32'h0000_0000);
      do_cmd(1'b0, 7'h00, 32'h0000_0000);
      // Let the last command execute; eight reads and three writes may
      // strobe, masked ones and dummy read data must not
      repeat (16) @(posedge core_clk);
      #1 chk({36'h0, err_cnt, rd_cnt, wr_cnt}, {36'h0, 12'h083});
   endtask

   // Short frame is refused but still sends status; a long frame keeps
   // its last forty bits and passes the first ones through
   task automatic t_link_faults();
      bb_frame(8, 64'h0);
      chk({40'h0, rx[7:0]}, {40'h0, stat2});
      bb_frame(48, {16'h0, 8'hE7, 8'h85, 32'h1234_5678});
      chk(rx[47:0], {stat2, 32'h0000_0000, 8'hE7});
      chk({8'h00, 1'b0, waddr2, wdata2}, {16'h0005, 32'h1234_5678});
      chk({40'h0, wr2_cnt, err2_cnt}, {40'h0, 4'h1, 4'h1});
      bb_frame(40, {24'h0, 8'h05, 32'hFFFF_FFFF});
      chk({8'h00, rx[39:0]}, {8'h00, stat2, 32'h1234_5678});
   endtask

   task automatic give_verdict();
      $display("checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      for (int i = 0; i < 128; i++) begin
         regs[i] = 32'hC0DE_0000 | 32'(i);
         exp_regs[i] = 32'hC0DE_0000 | 32'(i);
      end
      repeat (5) @(posedge core_clk);
      #1 rstn = 1'b1;
      repeat (4) @(posedge core_clk);
      t_pipeline();
      t_masks();
      t_link_faults();
      give_verdict();
   end

   // Watchdog, about three times the expected run of some 120 us
   initial begin
      #400000;
      num_errors++;
      give_verdict();
   end
endmodule

`default_nettype wire
